/* gpc_pkg.sv */
package gpc_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] PIN2_CONFIG_ADDR         = 8'h13;
   localparam logic [7:0] CHIP_IDENTIFICATION_ADDR = 8'h14;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int DIR_BIT    = 0;
   localparam int LEVEL_BIT  = 1;
   localparam int DRV_BIT    = 2;
   localparam int OUT_BIT    = 3;
   localparam int DBEN_BIT   = 4;
   localparam int ALT_BIT    = 5;
   localparam int CID_HI_BIT = 7;
   localparam int CID_HI_SRC = 4;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic RST_DIR  = 1'h1;
   localparam logic RST_DRV  = 1'h0;
   localparam logic RST_OUT  = 1'h0;
   localparam logic RST_DBEN = 1'h0;
   localparam logic RST_ALT  = 1'h0;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 5;
   localparam int DEBOUNCE_MS     = 30;
   localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int DB_CNT_W        = 23;

   typedef struct packed {
      logic alternate_function_select;
      logic input_debounce_enable;
      logic general_output_setting;
      logic driver_type;
      logic direction;
   } gpc_cfg_t;

   typedef struct packed {
      logic out;
      logic oe;
   } gpc_drive_t;

endpackage

/* gpc_debounce.sv */
module gpc_debounce #(
   parameter int unsigned STABLE_CYCLES = gpc_pkg::DEBOUNCE_CYCLES
) (
   input  wire logic core_clk_i,
   input  wire logic reset_i,
   input  wire logic enable_i,
   input  wire logic level_i,
   output logic      level_o
);

   logic [gpc_pkg::DB_CNT_W-1:0] count;
   logic                         seen;
   wire                          differs = (level_i != level_o);
   wire                          expired = (count >= gpc_pkg::DB_CNT_W'(STABLE_CYCLES - 1));

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         count   <= '0;
         level_o <= 1'h0;
         seen    <= 1'h0;
      end else if (!enable_i || !seen) begin
         count   <= '0;
         level_o <= level_i;
         seen    <= 1'h1;
      end else if (!differs) begin
         count   <= '0;
      end else if (expired) begin
         count   <= '0;
         level_o <= level_i;
      end else begin
         count   <= count + gpc_pkg::DB_CNT_W'(1);
      end
   end

   a_db_hold_level : assert property (@(posedge core_clk_i) disable iff (reset_i)
      enable_i && seen && $past(enable_i) && $past(seen) && !$past(expired)
      |-> level_o == $past(level_o))
      else $error("debounced level changed before stable time");

   a_db_accept : assert property (@(posedge core_clk_i) disable iff (reset_i)
      enable_i && seen && differs && expired |=> level_o == $past(level_i))
      else $error("stable level not accepted");

endmodule

/* gpc_pin2.sv */
module gpc_pin2 #(
   parameter logic        ALT_RESET      = 1'h0,
   parameter logic [4:0]  CHIP_ID_CODE   = 5'h00, // Arbitrary value
   parameter int unsigned DEBOUNCE_TICKS = gpc_pkg::DEBOUNCE_CYCLES
) (
   input  wire logic       core_clk_i,
   input  wire logic       reset_i,
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_write_i,
   input  wire logic       reg_read_i,
   output logic [7:0]      reg_rdata_o,
   input  wire logic       pin_i,
   output logic            pin_o,
   output logic            pin_oe_o,
   output logic            low_power_bias_o
);

   // ---------------------------------------------------------------
   // Configuration register
   // ---------------------------------------------------------------
   gpc_pkg::gpc_cfg_t cfg;
   gpc_pkg::gpc_drive_t next_drive;
   logic              input_level;

   wire sel_cfg = (reg_addr_i == gpc_pkg::PIN2_CONFIG_ADDR);
   wire sel_cid = (reg_addr_i == gpc_pkg::CHIP_IDENTIFICATION_ADDR);
   wire wr_cfg  = reg_write_i && sel_cfg;

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cfg.alternate_function_select <= ALT_RESET;
         cfg.input_debounce_enable     <= gpc_pkg::RST_DBEN;
         cfg.general_output_setting    <= gpc_pkg::RST_OUT;
         cfg.driver_type               <= gpc_pkg::RST_DRV;
         cfg.direction                 <= gpc_pkg::RST_DIR;
      end else if (wr_cfg) begin
         cfg.alternate_function_select <= reg_wdata_i[gpc_pkg::ALT_BIT];
         cfg.input_debounce_enable     <= reg_wdata_i[gpc_pkg::DBEN_BIT];
         cfg.general_output_setting    <= reg_wdata_i[gpc_pkg::OUT_BIT];
         cfg.driver_type               <= reg_wdata_i[gpc_pkg::DRV_BIT];
         cfg.direction                 <= reg_wdata_i[gpc_pkg::DIR_BIT];
      end
   end

   // Alternate bit keeps its factory value until software writes it
   logic alt_eff;
   assign alt_eff = cfg.alternate_function_select;

   // ---------------------------------------------------------------
   // Pin drive
   // ---------------------------------------------------------------
   wire is_output = !cfg.direction;
   assign next_drive.out = 1'h0;
   assign next_drive.oe  = is_output &&
                           (!cfg.general_output_setting || cfg.driver_type);
   wire next_pin = is_output && cfg.general_output_setting && cfg.driver_type;

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         pin_o            <= 1'h0;
         pin_oe_o         <= 1'h0;
         low_power_bias_o <= 1'h0;
      end else begin
         pin_o            <= next_pin | next_drive.out;
         pin_oe_o         <= next_drive.oe;
         low_power_bias_o <= alt_eff;
      end
   end

   // ---------------------------------------------------------------
   // Input path
   // ---------------------------------------------------------------
   gpc_debounce #(
      .STABLE_CYCLES (DEBOUNCE_TICKS)
   ) u_debounce (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .enable_i   (cfg.input_debounce_enable),
      .level_i    (pin_i),
      .level_o    (input_level)
   );

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   wire [7:0] cfg_rd = {2'h0, alt_eff, cfg.input_debounce_enable,
                        cfg.general_output_setting, cfg.driver_type,
                        input_level, cfg.direction};
   wire [7:0] cid_rd = {CHIP_ID_CODE[gpc_pkg::CID_HI_SRC], 3'h0,
                        CHIP_ID_CODE[3:0]};
   wire [7:0] next_rdata = sel_cfg ? cfg_rd : (sel_cid ? cid_rd : 8'h00);

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_read_i) begin
         reg_rdata_o <= next_rdata;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_input_undriven : assert property (@(posedge core_clk_i) disable iff (reset_i)
      cfg.direction |=> !pin_oe_o)
      else $error("pin driven while input");

   a_output_low : assert property (@(posedge core_clk_i) disable iff (reset_i)
      !cfg.direction && !cfg.general_output_setting |=> pin_oe_o && !pin_o)
      else $error("output low not driven");

   a_high_drive : assert property (@(posedge core_clk_i) disable iff (reset_i)
      !cfg.direction && cfg.general_output_setting
      |=> pin_oe_o == $past(cfg.driver_type) && pin_o == $past(cfg.driver_type))
      else $error("output high drive wrong");

   a_cid_read : assert property (@(posedge core_clk_i) disable iff (reset_i)
      reg_read_i && sel_cid |=> reg_rdata_o == {CHIP_ID_CODE[4], 3'h0, CHIP_ID_CODE[3:0]})
      else $error("id read wrong");

   a_cfg_write : assert property (@(posedge core_clk_i) disable iff (reset_i)
      wr_cfg |=> cfg.direction == $past(reg_wdata_i[gpc_pkg::DIR_BIT])
                 && cfg.driver_type == $past(reg_wdata_i[gpc_pkg::DRV_BIT])
                 && cfg.general_output_setting == $past(reg_wdata_i[gpc_pkg::OUT_BIT])
                 && cfg.input_debounce_enable == $past(reg_wdata_i[gpc_pkg::DBEN_BIT]))
      else $error("config write lost");

   a_level_read : assert property (@(posedge core_clk_i) disable iff (reset_i)
      reg_read_i && sel_cfg |=> reg_rdata_o[1] == $past(input_level))
      else $error("level bit wrong");

   a_alt_follow : assert property (@(posedge core_clk_i) disable iff (reset_i)
      wr_cfg |=> ##1 low_power_bias_o == $past(reg_wdata_i[gpc_pkg::ALT_BIT], 2))
      else $error("bias select wrong");

   a_rsvd_zero : assert property (@(posedge core_clk_i) disable iff (reset_i)
      reg_read_i && sel_cfg |=> reg_rdata_o[7:6] == 2'h0 && reg_rdata_o[5] == $past(alt_eff))
      else $error("alt field read wrong");

   a_od_release : assert property (@(posedge core_clk_i) disable iff (reset_i)
      !cfg.direction && cfg.general_output_setting && !cfg.driver_type |=> !pin_oe_o)
      else $error("open-drain high not released");

   a_cfg_hold : assert property (@(posedge core_clk_i) disable iff (reset_i)
      !wr_cfg |=> $stable(cfg))
      else $error("config changed without write");

   a_bias_steady : assert property (@(posedge core_clk_i) disable iff (reset_i)
      !wr_cfg |=> ##1 $stable(low_power_bias_o))
      else $error("bias select moved without write");

   a_cfg_read : assert property (@(posedge core_clk_i) disable iff (reset_i)
      reg_read_i && sel_cfg |=> reg_rdata_o[gpc_pkg::DIR_BIT] == $past(cfg.direction)
         && reg_rdata_o[gpc_pkg::DRV_BIT] == $past(cfg.driver_type)
         && reg_rdata_o[gpc_pkg::OUT_BIT] == $past(cfg.general_output_setting)
         && reg_rdata_o[gpc_pkg::DBEN_BIT] == $past(cfg.input_debounce_enable))
      else $error("config read wrong");

   a_level_follow : assert property (@(posedge core_clk_i) disable iff (reset_i)
      !cfg.input_debounce_enable |=> input_level == $past(pin_i))
      else $error("input level lags pin");

   a_unmapped_read : assert property (@(posedge core_clk_i) disable iff (reset_i)
      reg_read_i && !sel_cfg && !sel_cid |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");

   a_rdata_hold : assert property (@(posedge core_clk_i) disable iff (reset_i)
      !reg_read_i |=> $stable(reg_rdata_o))
      else $error("read data moved without read");

endmodule

/* gpc_pin_model.sv */
module gpc_pin_model (
   input  wire logic pin_o,
   input  wire logic pin_oe_o,
   input  wire logic ext_en_i,
   input  wire logic ext_level_i,
   output logic      pin_level_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Board pull-up holds the line high when nobody drives it
   assign pin_level_o = pin_oe_o ? pin_o : (ext_en_i ? ext_level_i : 1'b1);
endmodule

/* gpio2_pin_config_and_chip_id_bench.sv */
`define CHK(g, e) begin \
   samples_checked++; \
   if ((g) !== (e)) begin \
      fail_count++; \
      $display("[FAIL] %0t got %h exp %h", $time, g, e); \
   end \
end

module gpio2_pin_config_and_chip_id_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic       core_clk_i = 1'b0;
   logic       reset_i    = 1'b1;
   logic       wr         = 1'b0;
   logic       rd         = 1'b0;
   logic       ext_en     = 1'b0;
   logic       ext_lv     = 1'b1;
   logic [7:0] addr       = 8'h00;
   logic [7:0] wdata      = 8'h00;
   logic [7:0] rdata;
   logic [7:0] d;
   logic [7:0] e;
   logic       pin_o;
   logic       pin_oe;
   logic       lpb;
   logic       pin_lvl;
   logic       oe_e;
   logic [1:0] pend       = 2'h0;
   logic [7:0] exp_q[$];
   int         fail_count = 0;
   int         samples_checked = 0;
   int         i;

   initial forever #2.5 core_clk_i = ~core_clk_i;

   gpc_pin2 #(.ALT_RESET(1'h1), .CHIP_ID_CODE(5'h15), .DEBOUNCE_TICKS(8)) dut (
      .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_write_i(wr), .reg_read_i(rd),
      .reg_rdata_o(rdata), .pin_i(pin_lvl), .pin_o(pin_o),
      .pin_oe_o(pin_oe), .low_power_bias_o(lpb));

   gpc_pin_model model (.pin_o(pin_o), .pin_oe_o(pin_oe), .ext_en_i(ext_en),
      .ext_level_i(ext_lv), .pin_level_o(pin_lvl));

   // ---------------------------------------------------------------
   // Read monitor
   // ---------------------------------------------------------------
   always @(posedge core_clk_i) pend <= {pend[0], rd};
   always @(negedge core_clk_i) if (pend[1]) begin
      e = exp_q.pop_front();
      `CHK(rdata, e)
   end

   task automatic idle(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask

   task automatic wr8(input logic [7:0] a, input logic [7:0] v);
      @(negedge core_clk_i);
      addr = a;
      wdata = v;
      wr = 1'b1;
      @(negedge core_clk_i);
      wr = 1'b0;
   endtask

   task automatic rd8(input logic [7:0] a, input logic [7:0] v);
      @(negedge core_clk_i);
      addr = a;
      rd = 1'b1;
      exp_q.push_back(v);
      @(negedge core_clk_i);
      rd = 1'b0;
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge core_clk_i);
      fail_count++;
      conclude;
   end

   initial begin
      d = $urandom(50);
      idle(20);
      reset_i = 1'b0;
      rd8(8'h13, 8'h23);
      `CHK({lpb, pin_oe}, 2'h2)
      wr8(8'h14, 8'hff);
      rd8(8'h14, 8'h85);
      rd8(8'h20, 8'h00);
      $display("test reset_and_id done");
      for (i = 0; i < 16; i++) begin
         // Reserved bits kept zero
         d = {2'h0, 1'($urandom), 1'h0, i[2:1], 1'($urandom), i[0]};
         wr8(8'h13, d);
         idle(2);
         oe_e = !d[0] && (!d[3] || d[2]);
         `CHK(pin_oe, oe_e)
         `CHK(pin_o & oe_e, d[3] & oe_e)
         `CHK(pin_oe & pin_o, !d[0] & d[3] & d[2])
         `CHK(lpb, d[5])
         rd8(8'h13, {2'h0, d[5:2], oe_e ? d[3] : 1'b1, d[0]});
      end
      $display("test drive_table done");
      wr8(8'h13, 8'h11);
      ext_en = 1'b1;
      ext_lv = 1'b0;
      idle(4);
      ext_lv = 1'b1;
      idle(2);
      rd8(8'h13, 8'h13);
      ext_lv = 1'b0;
      idle(14);
      rd8(8'h13, 8'h11);
      $display("test debounce done");
      for (i = 0; i < 20 && exp_q.size() != 0; i++) idle(1);
      if (exp_q.size() != 0) fail_count++;
      conclude;
   end
endmodule
